// [pkg/cris_pkg.sv]
package cris_pkg;

  // ----------------------------------------------------------------
  // Register space
  // ----------------------------------------------------------------
  localparam int        REG_DEPTH    = 128;
  localparam int        REG_AW       = 7;
  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [6:0] ADDR_SEL_OFS = 7'h00;
  localparam int        ADDR_SEL_BIT = 0;

  // ----------------------------------------------------------------
  // Bus addresses and command codes
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_PRI = 7'h6a; // 0xd4 as a write address.
  localparam logic [6:0] DEV_ADDR_ALT = 7'h68; // 0xd0 as a write address.
  localparam logic [7:0] CMD_SAVE     = 8'hf0;
  localparam logic [7:0] CMD_RESTORE  = 8'hf1;

  // ----------------------------------------------------------------
  // Serial framing counts
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [6:0] IDX_LAST = 7'h7f;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LP_ADDR, LP_WR, LP_RD, LP_IGN} cris_lphase_t;
  typedef enum logic [1:0] {NV_IDLE, NV_ISSUE, NV_WAIT} cris_nv_st_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cris_nv_req_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } cris_rxev_t;

endpackage : cris_pkg

// [design/cris_cfg_bank.sv]
`timescale 1ns/1ps
// Active configuration bytes plus a staging copy; a commit moves every
// pending staged byte into the active set on one clock edge.
module cris_cfg_bank (
  // Clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  // Staging port
  input  wire logic                              stg_we,
  input  wire logic [cris_pkg::REG_AW-1:0]       stg_addr,
  input  wire logic [7:0]                        stg_data,
  input  wire logic                              commit,
  // Direct load port
  input  wire logic                              ld_we,
  input  wire logic [cris_pkg::REG_AW-1:0]       ld_addr,
  input  wire logic [7:0]                        ld_data,
  // Read port
  input  wire logic [cris_pkg::REG_AW-1:0]       rd_addr,
  output logic [7:0]                             rd_data,
  output logic [8*cris_pkg::REG_DEPTH-1:0]       cfg_q
);

  logic [7:0] act_r [cris_pkg::REG_DEPTH];
  logic [7:0] stg_r [cris_pkg::REG_DEPTH];
  logic       pend_r [cris_pkg::REG_DEPTH];

  // ----------------------------------------------------------------
  // Byte cells
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < cris_pkg::REG_DEPTH; i++)
    begin : g_cell
      wire ld_hit  = ld_we && (ld_addr == cris_pkg::REG_AW'(i));
      wire stg_hit = stg_we && (stg_addr == cris_pkg::REG_AW'(i));
      // A direct load wins over a commit; the two never meet in use.
      always_ff @(posedge clk)
      begin
        if (!rst_b)
        begin
          act_r[i]  <= cris_pkg::RST_BYTE;
          stg_r[i]  <= cris_pkg::RST_BYTE;
          pend_r[i] <= 1'b0;
        end
        else
        begin
          if (ld_hit)
            act_r[i] <= ld_data;
          else if (commit && pend_r[i])
            act_r[i] <= stg_r[i];
          if (stg_hit)
          begin
            stg_r[i]  <= stg_data;
            pend_r[i] <= 1'b1;
          end
          else if (commit)
            pend_r[i] <= 1'b0;
        end
      end
      assign cfg_q[i*8 +: 8] = act_r[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rd_data <= cris_pkg::RST_BYTE;
    else
      rd_data <= act_r[rd_addr];
  end

endmodule : cris_cfg_bank

// [design/cris_i2c_slave.sv]
`timescale 1ns/1ps
// Functional notes
// - Answer as target at one of two seven-bit addresses, picked by configuration.
// - Support block writes and block reads of any number of consecutive bytes.
// - First written byte after the address loads the register pointer.
// - Pointer advances by one after each data byte, lowest offset upward.
// - Data bytes travel most significant bit first in both directions.
// - A transfer may end after any complete byte.
// - Written bytes are held in staging; no register changes before STOP.
// - At STOP all staged bytes enter their registers on one edge.
// - Primary address by default; alternate when the select bit is set.
// - Save or restore is a two-byte write of address and command, run after STOP.
// - No acknowledges while save or restore runs; resume once finished.
// - Restore automatically after reset; acknowledge address only when ready.
module cris_i2c_slave (
  // System clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst_b,
  // Serial link
  input  wire logic                          scl,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe,
  // Non-volatile store
  output cris_pkg::cris_nv_req_t             nv_cmd,
  input  wire logic                          nv_ack,
  input  wire logic [7:0]                    nv_rdata,
  // Configuration consumers
  output logic [8*cris_pkg::REG_DEPTH-1:0]   cfg_bytes,
  output logic                               cfg_upd,
  output logic                               busy
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                   link_clr_r;
  logic                   link_rst_r;
  logic                   rdy_r;
  logic                   asel_r;
  logic [7:0]             tx_byte_r;
  logic                   rd_oob_r;
  logic                   rdy_s1_r;
  logic                   rdy_s2_r;
  logic                   asel_s1_r;
  logic                   asel_s2_r;
  logic [3:0]             bit_cnt_r;
  logic [7:0]             sh_r;
  cris_pkg::cris_lphase_t phase_r;
  logic                   ack_r;
  logic                   first_r;
  cris_pkg::cris_rxev_t   rx_ev_r;
  logic                   wr_tgl_r;
  logic                   rd_tgl_r;
  logic [7:0]             tx_sh_r;
  logic                   scl_s1_r;
  logic                   scl_s2_r;
  logic                   sda_s1_r;
  logic                   sda_s2_r;
  logic                   sda_d_r;
  logic                   wt_s1_r;
  logic                   wt_s2_r;
  logic                   wt_d_r;
  logic                   rt_s1_r;
  logic                   rt_s2_r;
  logic                   rt_d_r;
  logic [7:0]             ptr_r;
  logic                   staged_r;
  logic                   cand_r;
  logic [7:0]             cmd_r;
  logic                   commit_r;
  cris_pkg::cris_nv_st_t  nv_st_r;
  cris_pkg::cris_nv_st_t  nv_st_nxt;
  logic                   nv_save_r;
  logic [6:0]             idx_r;
  logic [7:0]             rd_data;
  logic [7:0]             save_byte;

  // ----------------------------------------------------------------
  // Link side decode
  // ----------------------------------------------------------------
  wire [7:0] rx_byte  = {sh_r[6:0], sda_i};
  wire [6:0] own_addr = asel_s2_r ? cris_pkg::DEV_ADDR_ALT
                                  : cris_pkg::DEV_ADDR_PRI;
  wire addr_hit = (rx_byte[7:1] == own_addr) && rdy_s2_r;
  wire byte_end = (bit_cnt_r == cris_pkg::BIT_LAST);
  wire ack_slot = (bit_cnt_r == cris_pkg::BIT_ACK);
  wire rd_data_slot = (phase_r == cris_pkg::LP_RD) && !ack_r;

  // ----------------------------------------------------------------
  // Link domain: quasi-static levels from the system side
  // ----------------------------------------------------------------
  // Cleared at every START; two link edges refill them long before
  // the address byte is complete.
  always_ff @(posedge scl or posedge link_clr_r)
  begin
    if (link_clr_r)
    begin
      rdy_s1_r  <= 1'b0;
      rdy_s2_r  <= 1'b0;
      asel_s1_r <= 1'b0;
      asel_s2_r <= 1'b0;
    end
    else
    begin
      rdy_s1_r  <= rdy_r;
      rdy_s2_r  <= rdy_s1_r;
      asel_s1_r <= asel_r;
      asel_s2_r <= asel_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: receive framing
  // ----------------------------------------------------------------
  // Cleared at START so every frame, repeated or not, begins with an
  // address byte.
  always_ff @(posedge scl or posedge link_clr_r)
  begin
    if (link_clr_r)
    begin
      bit_cnt_r <= 4'h0;
      sh_r      <= 8'h00;
      phase_r   <= cris_pkg::LP_ADDR;
      ack_r     <= 1'b0;
      first_r   <= 1'b0;
    end
    else if (ack_slot)
    begin
      bit_cnt_r <= 4'h0;
      ack_r     <= 1'b0;
      if (rd_data_slot && sda_i)
        phase_r <= cris_pkg::LP_IGN;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      sh_r      <= rx_byte;
      if (byte_end)
      begin
        case (phase_r)
          cris_pkg::LP_ADDR:
          begin
            ack_r   <= addr_hit;
            first_r <= 1'b1;
            if (!addr_hit)
              phase_r <= cris_pkg::LP_IGN;
            else if (rx_byte[0])
              phase_r <= cris_pkg::LP_RD;
            else
              phase_r <= cris_pkg::LP_WR;
          end
          cris_pkg::LP_WR:
          begin
            ack_r   <= 1'b1;
            first_r <= 1'b0;
          end
          default:
            ack_r <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: events toward the system side
  // ----------------------------------------------------------------
  // Only the system reset clears these; a START must not fake a toggle.
  always_ff @(posedge scl or posedge link_rst_r)
  begin
    if (link_rst_r)
    begin
      rx_ev_r  <= '0;
      wr_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
    end
    else if (byte_end && phase_r == cris_pkg::LP_WR)
    begin
      rx_ev_r  <= '{first: first_r, data: rx_byte};
      wr_tgl_r <= ~wr_tgl_r;
    end
    else if (ack_slot && rd_data_slot)
      rd_tgl_r <= ~rd_tgl_r;
  end

  // ----------------------------------------------------------------
  // Link domain: open-drain drive on the falling edge
  // ----------------------------------------------------------------
  always_ff @(negedge scl or posedge link_clr_r)
  begin
    if (link_clr_r)
    begin
      tx_sh_r <= 8'h00;
      sda_oe  <= 1'b0;
      sda_o   <= 1'b0;
    end
    else if (phase_r == cris_pkg::LP_RD && bit_cnt_r == 4'h0)
    begin
      tx_sh_r <= tx_byte_r;
      sda_oe  <= ~tx_byte_r[7];
    end
    else if (phase_r == cris_pkg::LP_RD && !bit_cnt_r[3])
    begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      sda_oe  <= ~tx_sh_r[6];
    end
    else
      sda_oe  <= ack_slot && ack_r;
  end

  // ----------------------------------------------------------------
  // System domain: pin and toggle synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      {scl_s1_r, scl_s2_r} <= 2'b11;
      {sda_s1_r, sda_s2_r, sda_d_r} <= 3'b111;
      {wt_s1_r, wt_s2_r, wt_d_r} <= 3'b000;
      {rt_s1_r, rt_s2_r, rt_d_r} <= 3'b000;
    end
    else
    begin
      scl_s1_r <= scl;
      scl_s2_r <= scl_s1_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r  <= sda_s2_r;
      wt_s1_r  <= wr_tgl_r;
      wt_s2_r  <= wt_s1_r;
      wt_d_r   <= wt_s2_r;
      rt_s1_r  <= rd_tgl_r;
      rt_s2_r  <= rt_s1_r;
      rt_d_r   <= rt_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // System domain: decode of bus conditions and link events
  // ----------------------------------------------------------------
  wire bus_start = scl_s2_r && sda_d_r && !sda_s2_r;
  wire bus_stop  = scl_s2_r && !sda_d_r && sda_s2_r;
  wire wr_ev     = wt_s2_r ^ wt_d_r;
  wire rd_ev     = rt_s2_r ^ rt_d_r;
  wire off_ev    = wr_ev && rx_ev_r.first;
  wire dat_ev    = wr_ev && !rx_ev_r.first;
  wire is_cmd    = (rx_ev_r.data == cris_pkg::CMD_SAVE) ||
                   (rx_ev_r.data == cris_pkg::CMD_RESTORE);
  wire launch    = bus_stop && cand_r && (nv_st_r == cris_pkg::NV_IDLE);
  wire stg_we    = dat_ev && !ptr_r[7];
  wire ld_we     = (nv_st_r == cris_pkg::NV_WAIT) && nv_ack && !nv_save_r;

  // ----------------------------------------------------------------
  // System domain: link clear control
  // ----------------------------------------------------------------
  // Raised by START or STOP and dropped once the clock is seen low,
  // which is well before the first data edge of the frame.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      link_clr_r <= 1'b1;
      link_rst_r <= 1'b1;
    end
    else
    begin
      link_rst_r <= 1'b0;
      if (bus_start || bus_stop)
        link_clr_r <= 1'b1;
      else if (!scl_s2_r)
        link_clr_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System domain: pointer, staging and commit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ptr_r    <= 8'h00;
      staged_r <= 1'b0;
      cand_r   <= 1'b0;
      cmd_r    <= 8'h00;
      commit_r <= 1'b0;
    end
    else
    begin
      commit_r <= bus_stop && staged_r;
      if (stg_we)
        staged_r <= 1'b1;
      else if (bus_stop)
        staged_r <= 1'b0;
      if (off_ev)
      begin
        ptr_r  <= rx_ev_r.data;
        cand_r <= is_cmd;
        cmd_r  <= rx_ev_r.data;
      end
      else if (dat_ev || rd_ev)
      begin
        ptr_r  <= ptr_r + 8'h01;
        cand_r <= 1'b0;
      end
      else if (bus_start || bus_stop)
        cand_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // System domain: save and restore sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nv_st_nxt = nv_st_r;
    case (nv_st_r)
      cris_pkg::NV_IDLE:
        if (launch)
          nv_st_nxt = cris_pkg::NV_ISSUE;
      cris_pkg::NV_ISSUE:
        nv_st_nxt = cris_pkg::NV_WAIT;
      cris_pkg::NV_WAIT:
        if (nv_ack)
          nv_st_nxt = (idx_r == cris_pkg::IDX_LAST) ? cris_pkg::NV_IDLE
                                                    : cris_pkg::NV_ISSUE;
      default:
        nv_st_nxt = cris_pkg::NV_IDLE;
    endcase
  end

  assign save_byte = cfg_bytes[{idx_r, 3'b000} +: 8];

  // Reset leaves the sequencer mid-restore, so the address is refused
  // until the stored image is back in the active registers.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      nv_st_r   <= cris_pkg::NV_ISSUE;
      nv_save_r <= 1'b0;
      idx_r     <= 7'h00;
      nv_cmd    <= '0;
      busy      <= 1'b1;
      rdy_r     <= 1'b0;
    end
    else
    begin
      nv_st_r <= nv_st_nxt;
      busy    <= (nv_st_nxt != cris_pkg::NV_IDLE);
      rdy_r   <= (nv_st_nxt == cris_pkg::NV_IDLE);
      if (launch)
      begin
        nv_save_r <= (cmd_r == cris_pkg::CMD_SAVE);
        idx_r     <= 7'h00;
      end
      if (nv_st_r == cris_pkg::NV_ISSUE)
        nv_cmd <= '{req: 1'b1, we: nv_save_r, addr: idx_r, wdata: save_byte};
      else if (nv_st_r == cris_pkg::NV_WAIT && nv_ack)
      begin
        nv_cmd.req <= 1'b0;
        idx_r      <= idx_r + 7'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // System domain: read prefetch and outward levels
  // ----------------------------------------------------------------
  // The byte to send always tracks the pointer, so it is settled long
  // before the link loads it after an acknowledge.
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rd_oob_r  <= 1'b0;
      tx_byte_r <= 8'h00;
      asel_r    <= 1'b0;
      cfg_upd   <= 1'b0;
    end
    else
    begin
      rd_oob_r  <= ptr_r[7];
      tx_byte_r <= rd_oob_r ? 8'h00 : rd_data;
      asel_r    <= cfg_bytes[{cris_pkg::ADDR_SEL_OFS, 3'b000} +
                             cris_pkg::ADDR_SEL_BIT];
      cfg_upd   <= commit_r;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  cris_cfg_bank u_bank (
    .clk      (mclk),
    .rst_b    (rst_b),
    .stg_we   (stg_we),
    .stg_addr (ptr_r[6:0]),
    .stg_data (rx_ev_r.data),
    .commit   (commit_r),
    .ld_we    (ld_we),
    .ld_addr  (idx_r),
    .ld_data  (nv_rdata),
    .rd_addr  (ptr_r[6:0]),
    .rd_data  (rd_data),
    .cfg_q    (cfg_bytes)
  );

endmodule : cris_i2c_slave

// [tb/cris_i2c_slave_asserts.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port checker for the configuration target
// ----------------------------------------------------------------
module cris_i2c_slave_asserts (
  // System clock and reset
  input wire logic                             mclk,
  input wire logic                             rst_b,
  // Serial link
  input wire logic                             scl,
  input wire logic                             sda_i,
  input wire logic                             sda_o,
  input wire logic                             sda_oe,
  // Non-volatile store
  input wire cris_pkg::cris_nv_req_t           nv_cmd,
  input wire logic                             nv_ack,
  input wire logic [7:0]                       nv_rdata,
  // Configuration consumers
  input wire logic [8*cris_pkg::REG_DEPTH-1:0] cfg_bytes,
  input wire logic                             cfg_upd,
  input wire logic                             busy
);
  // Everything here lives in the system clock domain.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // Open drain: the data value is never a driven high.
  drive_low_a : assert property (sda_o == 1'b0) else $error("data drive value not low");
  // Outside restore, the active set moves only in the commit cycle.
  cfg_stable_a : assert property ($changed(cfg_bytes) |-> cfg_upd || busy || $past(busy))
    else $error("config bytes changed without commit");
  upd_pulse_a : assert property (cfg_upd |=> !cfg_upd) else $error("commit pulse too long");
  // Store handshake: held until answered, then one idle cycle.
  req_gap_a : assert property (nv_ack |=> !nv_cmd.req) else $error("store request not dropped");
  req_hold_a : assert property (nv_cmd.req && !nv_ack |=> nv_cmd.req && $stable(nv_cmd))
    else $error("store request changed before answer");
  restore_start_a : assert property (!$past(rst_b) |=> nv_cmd.req && !nv_cmd.we && nv_cmd.addr == 7'h00)
    else $error("power-up restore did not start");
  addr_step_a : assert property (nv_ack && nv_cmd.addr != 7'h7f |-> ##2 nv_cmd.req &&
    nv_cmd.addr == 7'($past(nv_cmd.addr, 2) + 7'h01)) else $error("store address did not step");
  busy_end_a : assert property (nv_ack && nv_cmd.addr == 7'h7f |-> ##2 !busy)
    else $error("busy did not fall after last byte");
  busy_nack_a : assert property (busy |-> !sda_oe) else $error("acknowledge while busy");
endmodule : cris_i2c_slave_asserts

bind cris_i2c_slave cris_i2c_slave_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .nv_cmd(nv_cmd), .nv_ack(nv_ack), .nv_rdata(nv_rdata),
  .cfg_bytes(cfg_bytes), .cfg_upd(cfg_upd), .busy(busy));

// [tb/cris_i2c_master.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serial bus master model
// ----------------------------------------------------------------
// Steps on the link clock: 44 ticks low and 45 high keep every bus
// minimum; the clock stands high between frames.
module cris_i2c_master (
  // Link clock
  input wire logic lclk,
  // Bus lines
  input wire logic sda,
  output logic     scl,
  output logic     sda_m
);
  localparam int Q = 22;
  localparam int H = 45;

  // Both lines released at time zero; the pull-up makes them high.
  initial
  begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask : tick

  // One bit slot: data changes only while the clock is low.
  task automatic bitx(input logic o, output logic i);
    sda_m <= o;
    tick(Q);
    scl <= 1'b1;
    tick(H);
    i = sda;
    scl <= 1'b0;
    tick(Q);
  endtask : bitx

  // Works both from idle and as a repeated start.
  task automatic start();
    sda_m <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(H);
    sda_m <= 1'b0;
    tick(H);
    scl <= 1'b0;
    tick(Q);
  endtask : start

  task automatic stop();
    sda_m <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(H);
    sda_m <= 1'b1;
    tick(H);
  endtask : stop

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], d);
    bitx(1'b1, d);
    ack = !d;
  endtask : wr_byte

  // The last byte of a read is refused so the target lets go.
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, b[i]);
    bitx(last, d);
  endtask : rd_byte
endmodule : cris_i2c_master

// [tb/cris_i2c_slave_tb.sv]
`timescale 1ns/1ps
module cris_i2c_slave_tb;
  localparam logic [6:0] PRI = cris_pkg::DEV_ADDR_PRI;
  localparam logic [6:0] ALT = cris_pkg::DEV_ADDR_ALT;
  logic                             mclk = 1'b0;
  logic                             lclk;
  logic                             rst_b, nv_ack, slow, scl, sda_m, sda_o, sda_oe, cfg_upd, busy, ack_s;
  logic [7:0]                       nv_rdata, nvm [128], exp_b [128], wd [4];
  logic [31:0]                      seed;
  logic [6:0]                       off;
  int                               dly, n, fail_count, n_tests;
  cris_pkg::cris_nv_req_t           nv_cmd;
  logic [8*cris_pkg::REG_DEPTH-1:0] cfg_bytes;
  wire logic                        sda_i;

  // ----------------------------------------------------------------
  // Clocks, bus wiring and instances
  // ----------------------------------------------------------------
  always #25 mclk = ~mclk;
  // The link clock is offset so its edges drift against the system clock.
  initial
  begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end
  assign sda_i = (sda_oe ? sda_o : 1'b1) & sda_m;

  cris_i2c_master m (.lclk(lclk), .sda(sda_i), .scl(scl), .sda_m(sda_m));
  cris_i2c_slave uut (.mclk(mclk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .nv_cmd(nv_cmd), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .cfg_bytes(cfg_bytes), .cfg_upd(cfg_upd), .busy(busy));

  // Store model: answers after a random or a long wait; data toggles when idle.
  always @(posedge mclk)
  begin
    nv_rdata <= (nv_cmd.req && !nv_ack && dly == 0) ? nvm[nv_cmd.addr] : ~nv_rdata;
    if (nv_ack)
      nv_ack <= 1'b0;
    else if (nv_cmd.req && dly > 0)
      dly <= dly - 1;
    else if (nv_cmd.req)
    begin
      nv_ack   <= 1'b1;
      if (nv_cmd.we)
        nvm[nv_cmd.addr] <= nv_cmd.wdata;
      dly <= slow ? 20 : int'(seed[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic cmp_all();
    for (int i = 0; i < 128; i++)
      check("config byte", exp_b[i], cfg_bytes[8*i +: 8]);
  endtask : cmp_all

  // Bounded waits, sampled on the falling edge where outputs are settled.
  task automatic wait_busy_low();
    for (int i = 0; i < 5000 && busy !== 1'b0; i++)
      @(negedge mclk);
    check("busy", 8'h00, {7'h00, busy});
  endtask : wait_busy_low

  task automatic wait_upd();
    for (int i = 0; i < 200 && cfg_upd !== 1'b1; i++)
      @(negedge mclk);
    check("commit pulse", 8'h01, {7'h00, cfg_upd});
  endtask : wait_upd

  task automatic probe(input logic [6:0] dev, input logic exp_ack);
    logic a;
    m.start();
    m.wr_byte({dev, 1'b0}, a);
    m.stop();
    check("probe ack", {7'h00, exp_ack}, {7'h00, a});
  endtask : probe

  // Block write of wd[0..n-1]; nothing may land before the stop.
  task automatic wr_blk(input logic [6:0] dev, input logic [6:0] o, input int cnt);
    logic a;
    m.start();
    m.wr_byte({dev, 1'b0}, a);
    check("write address ack", 8'h01, {7'h00, a});
    m.wr_byte({1'b0, o}, a);
    for (int i = 0; i < cnt; i++)
      m.wr_byte(wd[i], a);
    cmp_all();
    fork
      m.stop();
      wait_upd();
    join
    for (int i = 0; i < cnt; i++)
      exp_b[7'(o + i)] = wd[i];
    cmp_all();
  endtask : wr_blk

  // Read with an offset phase, or from the current pointer without one.
  task automatic rd_blk(input logic [6:0] o, input logic use_off, input int cnt);
    logic       a;
    logic [7:0] b;
    if (use_off)
    begin
      m.start();
      m.wr_byte({PRI, 1'b0}, a);
      m.wr_byte({1'b0, o}, a);
    end
    m.start();
    m.wr_byte({PRI, 1'b1}, a);
    check("read address ack", 8'h01, {7'h00, a});
    for (int i = 0; i < cnt; i++)
    begin
      m.rd_byte(i == cnt - 1, b);
      check("read data", exp_b[7'(o + i)], b);
    end
    m.stop();
  endtask : rd_blk

  task automatic cmd(input logic [7:0] c);
    logic a;
    m.start();
    m.wr_byte({PRI, 1'b0}, a);
    m.wr_byte(c, a);
    m.stop();
    check("busy after command", 8'h01, {7'h00, busy});
  endtask : cmd

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (80000) @(posedge mclk);
    fail_count++;
    summarize();
  end

  initial
  begin
    seed = 32'd77951;
    fail_count = 0;
    n_tests = 0;
    slow = 1'b0;
    dly = 2;
    rst_b = 1'b0;
    nv_ack = 1'b0;
    nv_rdata = 8'h00;
    for (int i = 0; i < 128; i++)
    begin
      seed = rnd(seed);
      nvm[i] = seed[7:0];
    end
    nvm[0][0] = 1'b0;
    exp_b = nvm;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    wait_busy_low();
    cmp_all();
    // Random block writes, then offset read and current-pointer read.
    for (int k = 0; k < 3; k++)
    begin
      seed = rnd(seed);
      off = 7'h10 + {1'b0, seed[5:0]};
      n = (k == 0) ? 1 : 1 + int'(seed[9:8]);
      for (int i = 0; i < n; i++)
      begin
        seed = rnd(seed);
        wd[i] = seed[7:0];
      end
      wr_blk(PRI, off, n);
      rd_blk(off, 1'b1, n);
      rd_blk(7'(off + n), 1'b0, 2);
    end
    // Address select moves the target to the alternate address and back.
    probe(7'h20, 1'b0);
    wd[0] = exp_b[0] | 8'h01;
    wr_blk(PRI, 7'h00, 1);
    probe(PRI, 1'b0);
    wd[0] = exp_b[0] & 8'hfe;
    wr_blk(ALT, 7'h00, 1);
    probe(ALT, 1'b0);
    // A slow save must lock the target out until it finishes.
    slow = 1'b1;
    cmd(cris_pkg::CMD_SAVE);
    probe(PRI, 1'b0);
    wait_busy_low();
    slow = 1'b0;
    for (int i = 0; i < 128; i++)
      check("stored byte", exp_b[i], nvm[i]);
    // Restore discards a later write.
    wd[0] = ~exp_b[8'h40];
    wr_blk(PRI, 7'h40, 1);
    cmd(cris_pkg::CMD_RESTORE);
    wait_busy_low();
    exp_b = nvm;
    cmp_all();
    m.start();
    m.wr_byte({PRI, 1'b1}, ack_s);
    m.rd_byte(1'b1, wd[0]);
    m.stop();
    check("oob ack", 8'h01, {7'h00, ack_s});
    check("oob read", 8'h00, wd[0]);
    summarize();
  end
endmodule : cris_i2c_slave_tb
